//--- hw/tcc_ctrl.sv
// The address map and strobed register access were decided locally.
`timescale 1ns/10ps
// Behaviour
// - comparator runs only while its on bit is one
// - result pin drive bit forwards result to dedicated pin
// - invert bit flips result; result bit reads compare outcome after the invert bit
// - selected trigger condition sets the unit event flag
// - set event flag blocks further triggers and interrupts
// - select 11 fires on any result change while flag clear
// - select 10 fires on falling, or rising when inverted
// - select 01 fires on rising, or falling when inverted
// - select 00 never fires
// - noninv source bit picks internal reference or pin A
// - inverting input select picks pin B, C, D or half bandgap
// - idle stop bit masks interrupts in idle, operation continues
// - status bits 10..8 mirror event flags of units 3..1
// - status bits 2..0 mirror result bits of units 3..1
// - unimplemented bits ignore writes and read zero
// - reference power bit powers reference generator
// - reference pin bit connects reference level to its pin
// - range bit picks 0 plus n/24 or 1/4 plus n/32
// - span source bit picks external reference pins or supply
// - four bit level code picks one of sixteen levels
// - output pin carries unsynchronized result, no clocked path
module tcc_ctrl
  import tcc_pkg::*;
#(
  parameter int UNITS = NUM_UNITS
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  input wire logic idleMode,
  input wire logic [UNITS-1:0] analogRaw,
  output tcc_route_s [UNITS-1:0] unitRoute,
  output logic [UNITS-1:0] outPinData,
  output logic [UNITS-1:0] outPinEn,
  output tcc_ref_s refCtrl,
  output logic [UNITS-1:0] unitIrq,
  output logic [UNITS-1:0] unitTrigger
);

  // ==========================================================
  // state
  typedef struct packed {
    tcc_unit_s [UNITS-1:0] unit;
    tcc_ref_s refc;
    logic idleStop;
    logic [UNITS-1:0] sync1;
    logic [UNITS-1:0] sync2;
    logic [UNITS-1:0] prev;
    logic [UNITS-1:0] arm1;
    logic [UNITS-1:0] arm2;
    logic [UNITS-1:0] primed;
    logic [UNITS-1:0] irq;
    logic [UNITS-1:0] trig;
    logic [15:0] rdata;
  } tcc_state_s;

  tcc_state_s st;
  tcc_state_s next_st;
  logic [UNITS-1:0] resultBit;
  logic [UNITS-1:0] fire;
  logic [15:0] rdMux;

  // ==========================================================
  // per unit result and edge detection
  for (genvar u = 0; u < UNITS; u++) begin : g_unit
    logic rise;
    logic fall;
    logic hit;
    // polarity applied; disabled unit reads zero
    assign resultBit[u] = st.unit[u].on & (st.sync2[u] ^ st.unit[u].invert);
    // compare current and previous synchronized result
    assign rise = st.primed[u] & ~st.prev[u] & resultBit[u];
    assign fall = st.primed[u] & st.prev[u] & ~resultBit[u];
    always_comb begin
      case (st.unit[u].eventSelect)
        EVS_ANY: hit = rise | fall;
        EVS_FALL: hit = st.unit[u].invert ? rise : fall;
        EVS_RISE: hit = st.unit[u].invert ? fall : rise;
        default: hit = 1'b0;
      endcase
    end
    assign fire[u] = hit & ~st.unit[u].eventFlag;
    assign outPinData[u] = st.unit[u].pinDrive & st.unit[u].on
                           & (analogRaw[u] ^ st.unit[u].invert);
    assign outPinEn[u] = st.unit[u].on & st.unit[u].pinDrive;
    assign unitRoute[u].enable = st.unit[u].on;
    assign unitRoute[u].noninvFromRef = st.unit[u].noninvSource;
    assign unitRoute[u].invSelect = st.unit[u].invSelect;
  end

  // ==========================================================
  // read multiplexer
  always_comb begin
    rdMux = RST_VAL;
    if (regAddr < 4'(UNITS)) begin
      for (int i = 0; i < UNITS; i++) begin
        if (regAddr == 4'(i)) begin
          rdMux[CTL_ON] = st.unit[i].on;
          rdMux[CTL_PIN] = st.unit[i].pinDrive;
          rdMux[CTL_INV] = st.unit[i].invert;
          rdMux[CTL_EVT] = st.unit[i].eventFlag;
          rdMux[CTL_RES] = resultBit[i];
          rdMux[CTL_SEL_HI:CTL_SEL_LO] = st.unit[i].eventSelect;
          rdMux[CTL_NSRC] = st.unit[i].noninvSource;
          rdMux[CTL_CH_HI:CTL_CH_LO] = st.unit[i].invSelect;
        end
      end
    end else if (regAddr == STAT_ADDR) begin
      rdMux[STAT_IDLE] = st.idleStop;
      for (int i = 0; i < UNITS; i++) begin
        rdMux[STAT_EVT_LO + i] = st.unit[i].eventFlag;
      end
      for (int i = 0; i < UNITS; i++) begin
        rdMux[STAT_RES_LO + i] = resultBit[i];
      end
    end else if (regAddr == REFC_ADDR) begin
      rdMux[REF_PWR:0] = st.refc;
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    next_st.sync1 = analogRaw;
    next_st.sync2 = st.sync1;
    next_st.prev = resultBit;
    // primed once the synchronizer holds only enabled samples,
    // so stale levels from the off period never look like an edge
    for (int i = 0; i < UNITS; i++) begin
      next_st.arm1[i] = st.unit[i].on;
      next_st.arm2[i] = st.arm1[i] & st.unit[i].on;
      next_st.primed[i] = st.arm2[i] & st.unit[i].on;
    end
    next_st.rdata = regRd ? rdMux : RST_VAL;
    if (regWr) begin
      for (int i = 0; i < UNITS; i++) begin
        if (regAddr == 4'(i)) begin
          next_st.unit[i].on = regWdata[CTL_ON];
          next_st.unit[i].pinDrive = regWdata[CTL_PIN];
          next_st.unit[i].invert = regWdata[CTL_INV];
          // software write sets or clears flag
          next_st.unit[i].eventFlag = regWdata[CTL_EVT];
          next_st.unit[i].eventSelect = regWdata[CTL_SEL_HI:CTL_SEL_LO];
          next_st.unit[i].noninvSource = regWdata[CTL_NSRC];
          next_st.unit[i].invSelect = regWdata[CTL_CH_HI:CTL_CH_LO];
        end
      end
      if (regAddr == STAT_ADDR) begin
        next_st.idleStop = regWdata[STAT_IDLE];
      end
      if (regAddr == REFC_ADDR) begin
        next_st.refc = regWdata[REF_PWR:0];
      end
    end
    // event sets flag, set wins over a clearing write
    for (int i = 0; i < UNITS; i++) begin
      if (fire[i]) begin
        next_st.unit[i].eventFlag = 1'b1;
      end
      next_st.trig[i] = fire[i];
      // interrupt masked in idle when stop bit set
      next_st.irq[i] = fire[i] & ~(st.idleStop & idleMode);
    end
    if (srst) begin
      next_st = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    st <= next_st;
  end

  assign regRdata = st.rdata;
  assign refCtrl = st.refc;
  assign unitIrq = st.irq;
  assign unitTrigger = st.trig;

  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  for (genvar u = 0; u < UNITS; u++) begin : g_chk
    a_flag_on_event: assert property (fire[u] |=> st.unit[u].eventFlag)
      else $error("event flag not set");
    a_flag_blocks_fire: assert property (st.unit[u].eventFlag |-> !fire[u])
      else $error("event while flag set");
    a_none_never_fires: assert property (
      st.unit[u].eventSelect == EVS_NONE |-> !fire[u])
      else $error("event with select none");
    a_any_change_fires: assert property (
      st.unit[u].eventSelect == EVS_ANY && st.primed[u] && !st.unit[u].eventFlag
      && st.prev[u] != resultBit[u] |=> unitTrigger[u])
      else $error("change missed");
    a_rise_select: assert property (
      fire[u] && st.unit[u].eventSelect == EVS_RISE
      |-> resultBit[u] != st.unit[u].invert)
      else $error("wrong edge for rise select");
    a_fall_select: assert property (
      fire[u] && st.unit[u].eventSelect == EVS_FALL
      |-> resultBit[u] == st.unit[u].invert)
      else $error("wrong edge for fall select");
    a_pin_drive_off: assert property (!st.unit[u].pinDrive |-> !outPinEn[u])
      else $error("pin driven while disabled");
    a_off_no_result: assert property (!st.unit[u].on |-> !resultBit[u])
      else $error("result while off");
    a_idle_irq_mask: assert property (
      st.idleStop && idleMode && fire[u] |=> !unitIrq[u] && unitTrigger[u])
      else $error("irq in idle");
  end

  a_status_read: assert property (
    regRd && regAddr == STAT_ADDR |=> regRdata[7:UNITS] == '0
    && regRdata[14:8+UNITS] == '0)
    else $error("reserved status bits set");
  a_ref_read: assert property (
    regRd && regAddr == REFC_ADDR |=> regRdata[15:8] == 8'h00)
    else $error("reserved reference bits set");

  c_any_fire: cover property (fire[0] && st.unit[0].eventSelect == EVS_ANY);
  c_flag_clear: cover property (st.unit[0].eventFlag ##1 !st.unit[0].eventFlag);
  c_idle_mask: cover property (fire[0] && idleMode && st.idleStop);
  c_pin_on: cover property (outPinEn[2]);

endmodule // tcc_ctrl

//--- hw/tcc_pkg.sv
package tcc_pkg;
  // ==========================================================
  // register map (word indices on the plain register port)
  localparam logic [3:0] CTRL1_ADDR = 4'h0;
  localparam logic [3:0] CTRL2_ADDR = 4'h1;
  localparam logic [3:0] CTRL3_ADDR = 4'h2;
  localparam logic [3:0] STAT_ADDR = 4'h3;
  localparam logic [3:0] REFC_ADDR = 4'h4;
  localparam int NUM_UNITS = 3;
  // ==========================================================
  // control register fields
  localparam int CTL_ON = 15;
  localparam int CTL_PIN = 14;
  localparam int CTL_INV = 13;
  localparam int CTL_EVT = 9;
  localparam int CTL_RES = 8;
  localparam int CTL_SEL_HI = 7;
  localparam int CTL_SEL_LO = 6;
  localparam int CTL_NSRC = 4;
  localparam int CTL_CH_HI = 1;
  localparam int CTL_CH_LO = 0;
  localparam logic [15:0] CTL_WMASK = 16'hE2D3;
  // ==========================================================
  // status register fields
  localparam int STAT_IDLE = 15;
  localparam int STAT_EVT_LO = 8;
  localparam int STAT_RES_LO = 0;
  // ==========================================================
  // reference control fields
  localparam int REF_PWR = 7;
  localparam int REF_PIN = 6;
  localparam int REF_RNG = 5;
  localparam int REF_SRC = 4;
  localparam logic [15:0] REF_WMASK = 16'h00FF;
  // ==========================================================
  // event select codes and input routing codes
  localparam logic [1:0] EVS_NONE = 2'h0;
  localparam logic [1:0] EVS_RISE = 2'h1;
  localparam logic [1:0] EVS_FALL = 2'h2;
  localparam logic [1:0] EVS_ANY = 2'h3;
  localparam logic [1:0] INV_PIN_B = 2'h0;
  localparam logic [1:0] INV_PIN_C = 2'h1;
  localparam logic [1:0] INV_PIN_D = 2'h2;
  localparam logic [1:0] INV_HALF_BG = 2'h3;
  localparam logic [15:0] RST_VAL = 16'h0000;

  typedef struct packed {
    logic on;
    logic pinDrive;
    logic invert;
    logic eventFlag;
    logic [1:0] eventSelect;
    logic noninvSource;
    logic [1:0] invSelect;
  } tcc_unit_s;

  typedef struct packed {
    logic power;
    logic pinDrive;
    logic rangeSelect;
    logic spanSource;
    logic [3:0] levelCode;
  } tcc_ref_s;

  // per unit analog routing controls
  typedef struct packed {
    logic enable;
    logic noninvFromRef;
    logic [1:0] invSelect;
  } tcc_route_s;
endpackage

//--- dv/tcc_analog_model.sv
`timescale 1ns/10ps
// ==========================================================
// comparator cores and reference ladder
module tcc_analog_model
  import tcc_pkg::*;
(
  input tcc_route_s [2:0] unitRoute,
  input tcc_ref_s refCtrl,
  input wire logic [2:0][4:0] pinA,
  input wire logic [2:0][4:0] pinB,
  input wire logic [2:0][4:0] pinC,
  input wire logic [2:0][4:0] pinD,
  output logic [2:0] analogRaw
);
  localparam logic [4:0] HALF_BG = 5'h07; // arbitrary half bandgap level
  logic [4:0] refLevel;
  assign refLevel = refCtrl.power ? {1'b0, refCtrl.levelCode} : 5'h00;
  always_comb begin
    logic [4:0] pos;
    logic [4:0] neg;
    pos = 5'h00;
    neg = 5'h00;
    analogRaw = 3'h0;
    for (int i = 0; i < 3; i++) begin
      pos = unitRoute[i].noninvFromRef ? refLevel : pinA[i];
      case (unitRoute[i].invSelect)
        INV_PIN_B: neg = pinB[i];
        INV_PIN_C: neg = pinC[i];
        INV_PIN_D: neg = pinD[i];
        default: neg = HALF_BG;
      endcase
      // an idle core gives a level the block must ignore
      analogRaw[i] = unitRoute[i].enable ? (pos > neg) : 1'b1;
    end
  end
endmodule // tcc_analog_model

//--- dv/tb_triple_comparator_ctrl.sv
`timescale 1ns/10ps
module tb_triple_comparator_ctrl;
  import tcc_pkg::*;
  logic sys_clk = 0, srst = 1, regWr = 0, regRd = 0, idleMode = 0, rdFlag = 0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000, regRdata, ctl, r;
  logic [2:0] analogRaw, outPinData, outPinEn, unitIrq, unitTrigger;
  tcc_route_s [2:0] unitRoute;
  tcc_ref_s refCtrl;
  logic [2:0][4:0] pinA = '0, pinB = '0, pinC = '0, pinD = '0;
  logic [31:0] expQ[$];
  logic [31:0] q;
  int err_total = 0, total_checks = 0, irqCnt = 0, trigCnt = 0, c0, g0;
  // ==========================================================
  // design and far side
  tcc_ctrl #(.UNITS(3)) dut (.sys_clk(sys_clk), .srst(srst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .idleMode(idleMode), .analogRaw(analogRaw), .unitRoute(unitRoute),
    .outPinData(outPinData), .outPinEn(outPinEn), .refCtrl(refCtrl),
    .unitIrq(unitIrq), .unitTrigger(unitTrigger));
  tcc_analog_model model (.unitRoute(unitRoute), .refCtrl(refCtrl), .pinA(pinA),
    .pinB(pinB), .pinC(pinC), .pinD(pinD), .analogRaw(analogRaw));
  always #2.5 sys_clk = ~sys_clk;
  // ==========================================================
  // tasks
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    expQ.push_back({m, e});
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================================
  // monitors: pulse counts and read data
  always @(posedge sys_clk) begin
    rdFlag <= regRd;
    irqCnt += $countones(unitIrq);
    trigCnt += $countones(unitTrigger);
  end
  always @(negedge sys_clk) begin
    if (rdFlag) begin
      q = expQ.pop_front();
      cmp(regRdata & q[31:16], q[15:0]);
    end
  end
  initial begin
    #100000;
    err_total++;
    complete_run;
  end
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'hF553165B));
    wt(3);
    srst <= 1'b0;
    for (int a = 0; a < 8; a++) rd(4'(a), 16'hFFFF, 16'h0000);
    wr(CTRL3_ADDR, 16'h1D2C);
    rd(CTRL3_ADDR, 16'hFFFF, 16'h0000);
    for (int s = 0; s < 4; s++) begin
      for (int v = 0; v < 2; v++) begin
        ctl = {2'b11, v[0], 5'h00, s[1:0], 6'h00};
        wr(CTRL1_ADDR, 16'h0000);
        pinA[0] <= 5'h02;
        pinB[0] <= 5'h08;
        wr(CTRL1_ADDR, ctl);
        wt(8);
        c0 = irqCnt;
        pinA[0] <= 5'h0F;
        wt(8);
        cmp(outPinData[0], 16'(1 ^ v));
        cmp(outPinEn[0], 16'h0001);
        rd(STAT_ADDR, 16'h0101, {7'h00, s[0], 7'h00, ~v[0]});
        wr(CTRL1_ADDR, ctl);
        pinA[0] <= 5'h02;
        wt(8);
        pinA[0] <= 5'h0F;
        wt(8);
        // edge counts: first rise, falling edge, second rise
        g0 = s[0] + s[1] + (s[1] ? 0 : s[0]);
        cmp(16'(irqCnt - c0), 16'(g0));
      end
    end
    wr(STAT_ADDR, 16'hFFFF);
    rd(STAT_ADDR, 16'hFFFF, 16'h8100);
    wr(CTRL1_ADDR, 16'hC0C0);
    // polarity flip is a result change: clear the flag it set
    wr(CTRL1_ADDR, 16'hC0C0);
    idleMode <= 1'b1;
    wt(8);
    c0 = irqCnt;
    g0 = trigCnt;
    pinA[0] <= 5'h02;
    wt(8);
    cmp(16'(irqCnt - c0), 16'h0000);
    cmp(16'(trigCnt - g0), 16'h0001);
    idleMode <= 1'b0;
    r = 16'($urandom);
    wr(REFC_ADDR, r);
    rd(REFC_ADDR, 16'hFFFF, r & 16'h00FF);
    cmp(16'(refCtrl), r & 16'h00FF);
    wr(REFC_ADDR, 16'h0088);
    pinB[1] <= 5'h03;
    pinC[1] <= 5'h09;
    pinD[1] <= 5'h03;
    for (int ch = 0; ch < 4; ch++) begin
      wr(CTRL2_ADDR, 16'h8010 | 16'(ch));
      wt(6);
      cmp(16'(unitRoute[1]), 16'h000C | 16'(ch));
      rd(STAT_ADDR, 16'h0002, {14'h0000, 4'hD >> ch & 4'h1 ? 1'b1 : 1'b0, 1'b0});
    end
    wt(4);
    complete_run;
  end
endmodule // tb_triple_comparator_ctrl
